/* File: core/csw_crossbar_switch.sv */
// crossbar_switch: four masters to three slaves, per-slave arbitration
// assumes: masters hold request and payload while stalled; slaves answer
// with a one-cycle ready that ends the owner's transfer
// ------------------------------------------------------------
// Summary of operation
// - four masters, three slaves, parallel distinct pairs
// - every port has 32-bit address and data
// - two in flight, one is flash fetch
// - contested slave goes to higher priority
// - losers stall until owner completes
// - equal priority rotates after last granted master
// - fixed per-port priority used everywhere
// - elevation raises priority while requested
// - masters: fetch, load/store, dma, network
// - slaves: flash, sram, peripheral bridge
// ------------------------------------------------------------
`timescale 1ns/10ps
module csw_crossbar_switch
   import csw_pkg::*;
#(
   parameter int NM = NUM_MASTERS,                // master ports
   parameter int NS = NUM_SLAVES,                 // slave ports
   parameter int AW = ADDR_W,                     // address width
   parameter int DW = DATA_W                      // data width
) (
   input  wire logic                clk,          // system clock
   input  wire logic                rst,          // sync reset, active high
   input  wire logic [NM-1:0]       m_req,        // master transfer request
   input  wire logic [NM*SID_W-1:0] m_sel,        // target slave per master
   input  wire logic [NM*AW-1:0]    m_addr,       // master address
   input  wire logic [NM-1:0]       m_write,      // master write
   input  wire logic [NM*DW-1:0]    m_wdata,      // master write data
   input  wire logic [NM-1:0]       m_elev,       // priority elevation
   output logic      [NM-1:0]       m_ready,      // transfer accepted/complete
   output logic      [NM*DW-1:0]    m_rdata,      // read data to master
   output logic      [NS-1:0]       s_valid,      // transfer to slave
   output logic      [NS*AW-1:0]    s_addr,       // slave address
   output logic      [NS-1:0]       s_write,      // slave write
   output logic      [NS*DW-1:0]    s_wdata,      // slave write data
   output logic      [NS*MID_W-1:0] s_master,     // master_identifier on slave
   input  wire logic [NS-1:0]       s_ready,      // slave done this cycle
   input  wire logic [NS*DW-1:0]    s_rdata       // slave read data
);
   // ------------------------------------------------------------
   // state: registered read data per master
   // ------------------------------------------------------------
   typedef struct packed {
      logic [NM*DW-1:0] rdata;                    // captured read data
   } csw_top_s;
   csw_top_s cur_ff, nxt_ff;                      // register and next value

   logic [NS-1:0][NM-1:0] req_to;                 // per-slave request vectors
   logic [NS-1:0][NM-1:0] gnt;                    // per-slave grants
   logic [NS-1:0]         busy;                   // per-slave owned
   logic [NS-1:0][MID_W-1:0] own;                 // per-slave owner
   logic [NS-1:0][NM-1:0] allow;                  // in-flight gate per slave
   logic [NS-1:0][NM-1:0] conn;                   // effective connection
   logic [1:0]            inflight;               // owned ports count
   logic                  fetch_flash;            // flash owned by fetch port
   logic                  sram_asked;             // some master wants sram
   logic                  other_asked;            // some master wants sram or bridge

   // ------------------------------------------------------------
   // request decode
   // ------------------------------------------------------------
   always_comb begin
      req_to = '0;
      for (int m = 0; m < NM; m++) begin
         for (int s = 0; s < NS; s++) begin
            // slave index picks flash, sram or bridge
            req_to[s][m] = m_req[m] && (m_sel[m*SID_W +: SID_W] == SID_W'(s));
         end
      end
   end

   // ------------------------------------------------------------
   // concurrency limit: a second transfer only beside a flash fetch
   // ------------------------------------------------------------
   always_comb begin
      inflight    = '0;
      for (int s = 0; s < NS; s++) begin
         inflight = inflight + {1'b0, busy[s]};
      end
      fetch_flash = busy[S_FLASH] && (own[S_FLASH] == M_INSTR);
      // only requests and owned ports are read here, never grants, so the gate
      // cannot loop through the arbiters and every start it lets through sticks
      sram_asked  = (req_to[S_SRAM] != '0);
      other_asked = sram_asked || (req_to[S_PBRG] != '0);
      allow       = '0;
      for (int m = 0; m < NM; m++) begin
         if (inflight == 2'h0) begin
            // fetch to flash may pair with one more start; a non-fetch flash
            // start goes alone, and sram is kept over the bridge
            allow[S_FLASH][m] = (MID_W'(m) == M_INSTR) || !other_asked;
            allow[S_SRAM][m]  = 1'b1;
            allow[S_PBRG][m]  = !sram_asked;
         end else if (inflight == 2'h1 && fetch_flash) begin
            allow[S_SRAM][m]  = 1'b1;
            allow[S_PBRG][m]  = !sram_asked;
         end else if (inflight == 2'h1) begin
            allow[S_FLASH][m] = (MID_W'(m) == M_INSTR);
         end
      end
   end

   // a trade-off: the gate above already refuses what may not start, so a
   // grant is always a real connection; masking grants after the arbiters
   // would leave a port owned that no slave ever sees
   always_comb begin
      conn = gnt;                                 // distinct pairs in parallel
   end

   // ------------------------------------------------------------
   // one arbiter per slave port
   // ------------------------------------------------------------
   for (genvar s = 0; s < NS; s++) begin : g_arb
      logic [NM-1:0] arb_gnt;                     // raw grant
      csw_slave_arb #(.NM(NM)) u_arb (            // independent per slave
         .clk   (clk),
         .rst   (rst),
         .req   (req_to[s]),
         .elev  (m_elev),
         .allow (allow[s]),
         .done  (s_ready[s]),
         .gnt   (arb_gnt),
         .busy  (busy[s]),
         .owner (own[s])
      );
      assign gnt[s] = arb_gnt & ({NM{busy[s]}} | req_to[s]);
   end

   // ------------------------------------------------------------
   // slave-side mux: owner's payload, held stable by the master
   // ------------------------------------------------------------
   always_comb begin
      s_valid  = '0;
      s_addr   = '0;
      s_write  = '0;
      s_wdata  = '0;
      s_master = '0;
      for (int s = 0; s < NS; s++) begin
         for (int m = 0; m < NM; m++) begin
            if (conn[s][m] && m_req[m]) begin     // payload taken as held
               s_valid[s]                  = 1'b1;
               s_addr[s*AW +: AW]          = m_addr[m*AW +: AW];
               s_write[s]                  = m_write[m];
               s_wdata[s*DW +: DW]         = m_wdata[m*DW +: DW];
               s_master[s*MID_W +: MID_W]  = MID_W'(m);
            end
         end
      end
   end

   // ------------------------------------------------------------
   // master-side return: ready only from the owned slave, else stall
   // ------------------------------------------------------------
   always_comb begin
      m_ready = '0;
      nxt_ff  = cur_ff;
      for (int m = 0; m < NM; m++) begin
         for (int s = 0; s < NS; s++) begin
            if (conn[s][m] && busy[s] && s_ready[s]) begin
               m_ready[m]                = 1'b1;
               nxt_ff.rdata[m*DW +: DW]  = s_rdata[s*DW +: DW];
            end
         end
      end
      if (rst) begin
         nxt_ff = '0;
      end
   end

   always_ff @(posedge clk) begin
      cur_ff <= nxt_ff;
   end
   assign m_rdata = cur_ff.rdata;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   chk_inflight_max: assert property (@(posedge clk) disable iff (rst)
      inflight <= 2'h2) else $error("more than two transfers in flight");
   chk_pair_fetch: assert property (@(posedge clk) disable iff (rst)
      inflight == 2'h2 |-> fetch_flash)
      else $error("second transfer without flash fetch");
   chk_stall_loser: assert property (@(posedge clk) disable iff (rst)
      busy[S_SRAM] && m_req[own[S_SRAM]] |-> $onehot(conn[S_SRAM]))
      else $error("sram owned by more than one master");
   chk_ready_owner: assert property (@(posedge clk) disable iff (rst)
      m_ready[M_DMA] |-> $past(conn[S_FLASH][M_DMA] || conn[S_SRAM][M_DMA]
      || conn[S_PBRG][M_DMA]) && (conn[S_FLASH][M_DMA] || conn[S_SRAM][M_DMA]
      || conn[S_PBRG][M_DMA]))
      else $error("dma ready without connection");
   chk_rdata_cap: assert property (@(posedge clk) disable iff (rst)
      m_ready[M_INSTR] && conn[S_FLASH][M_INSTR]
      |=> m_rdata[DW-1:0] == $past(s_rdata[DW-1:0]))
      else $error("fetch data not captured");
   cov_fetch_pair: cover property (@(posedge clk) disable iff (rst) inflight == 2'h2);
   cov_contend: cover property (@(posedge clk) disable iff (rst)
      $countones(req_to[S_SRAM]) > 1);
   cov_elevate: cover property (@(posedge clk) disable iff (rst)
      m_elev[M_NET] && gnt[S_SRAM][M_NET] && req_to[S_SRAM][M_DATA]);
endmodule : csw_crossbar_switch

/* File: core/csw_slave_arb.sv */
// one slave-port arbiter: priority with round-robin tie break, hold till done
// assumes: requests and elevations come from same-clock logic
`timescale 1ns/10ps
module csw_slave_arb
   import csw_pkg::*;
#(
   parameter int NM = NUM_MASTERS                 // masters on this port
) (
   input  wire logic            clk,              // system clock
   input  wire logic            rst,              // sync reset, active high
   input  wire logic [NM-1:0]   req,              // masters asking for this slave
   input  wire logic [NM-1:0]   elev,             // priority elevation requests
   input  wire logic [NM-1:0]   allow,            // master may start (in-flight limit)
   input  wire logic            done,             // owner finished its transfers
   output logic      [NM-1:0]   gnt,              // one-hot ownership
   output logic                 busy,             // port owned
   output logic      [MID_W-1:0] owner            // owning master_identifier
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      csw_arb_e         st;                       // idle or owned
      logic [MID_W-1:0] own;                      // current owner
      logic [MID_W-1:0] last;                     // most recent grant
   } csw_arb_s;
   csw_arb_s cur_ff, nxt_ff;                      // register and next value

   localparam logic [PRIO_W-1:0] FIXED [NUM_MASTERS] =
      '{PRIO_INSTR, PRIO_DATA, PRIO_DMA, PRIO_NET};

   logic             pick_vld;                    // some eligible requester
   logic [MID_W-1:0] pick;                        // chosen master
   logic [PRIO_W-1:0] best;                       // its priority
   logic [PRIO_W-1:0] pr;                         // scratch priority
   logic [MID_W-1:0] idx;                         // scratch index

   // ------------------------------------------------------------
   // selection: scan from last+1 so equal priorities rotate
   // ------------------------------------------------------------
   always_comb begin
      pick_vld = 1'b0;
      pick     = '0;
      best     = '0;
      pr       = '0;
      idx      = '0;
      for (int k = 1; k <= NM; k++) begin
         idx = MID_W'(cur_ff.last + MID_W'(k));
         pr  = FIXED[idx] | (elev[idx] ? PRIO_BOOST : 3'h0);
         // strictly greater keeps the earliest in rotation on ties
         if (req[idx] && allow[idx] && (!pick_vld || pr > best)) begin
            pick_vld = 1'b1;
            pick     = idx;
            best     = pr;
         end
      end
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_ff = cur_ff;
      case (cur_ff.st)
         CSW_IDLE: begin
            if (pick_vld) begin                   // granted at once
               nxt_ff.st   = CSW_BUSY;
               nxt_ff.own  = pick;
               nxt_ff.last = pick;
            end
         end
         CSW_BUSY: begin
            if (done) begin                       // losers wait till here
               nxt_ff.st = CSW_IDLE;
            end
         end
         default: nxt_ff.st = CSW_IDLE;
      endcase
      if (rst) begin
         nxt_ff = '{CSW_IDLE, '0, LAST_GRANT_RST};
      end
   end

   always_ff @(posedge clk) begin
      cur_ff <= nxt_ff;
   end

   // grant is combinational from idle pick so an idle port costs no cycle
   always_comb begin
      gnt = '0;
      if (cur_ff.st == CSW_BUSY) begin
         gnt[cur_ff.own] = 1'b1;
      end else if (pick_vld) begin
         gnt[pick] = 1'b1;
      end
   end
   assign busy  = (cur_ff.st == CSW_BUSY);
   assign owner = cur_ff.own;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   chk_grant_onehot: assert property (@(posedge clk) disable iff (rst)
      $onehot0(gnt)) else $error("arbiter grant not one-hot");
   chk_owner_held: assert property (@(posedge clk) disable iff (rst)
      busy && !done |=> busy && owner == $past(owner))
      else $error("ownership lost before done");
   chk_idle_grant: assert property (@(posedge clk) disable iff (rst)
      !busy && $onehot(req & allow) |-> gnt == (req & allow))
      else $error("lone requester not granted at once");
endmodule : csw_slave_arb

/* File: include/csw_pkg.sv */
// crossbar switch package: port counts, widths, priorities, states
// assumes: single clock domain, synchronous active-high reset
package csw_pkg;
   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int NUM_MASTERS = 4;           // instr, load/store, dma, network
   localparam int NUM_SLAVES  = 3;           // flash, sram, peripheral bridge
   localparam int ADDR_W      = 32;          // address path width
   localparam int DATA_W      = 32;          // data path width
   localparam int MID_W       = 2;           // master_identifier width
   localparam int SID_W       = 2;           // slave index width
   // ------------------------------------------------------------
   // master and slave numbering
   // ------------------------------------------------------------
   localparam logic [MID_W-1:0] M_INSTR = 2'h0;  // processor instruction fetch
   localparam logic [MID_W-1:0] M_DATA  = 2'h1;  // processor load/store
   localparam logic [MID_W-1:0] M_DMA   = 2'h2;  // dma_master
   localparam logic [MID_W-1:0] M_NET   = 2'h3;  // network controller
   localparam logic [SID_W-1:0] S_FLASH = 2'h0;  // flash code and data
   localparam logic [SID_W-1:0] S_SRAM  = 2'h1;  // on-chip sram
   localparam logic [SID_W-1:0] S_PBRG  = 2'h2;  // peripheral bridge
   // ------------------------------------------------------------
   // fixed priorities, higher value wins; elevation adds PRIO_BOOST
   // ------------------------------------------------------------
   localparam int PRIO_W = 3;
   localparam logic [PRIO_W-1:0] PRIO_INSTR = 3'h1;
   localparam logic [PRIO_W-1:0] PRIO_DATA  = 3'h1;
   localparam logic [PRIO_W-1:0] PRIO_DMA   = 3'h0;
   localparam logic [PRIO_W-1:0] PRIO_NET   = 3'h0;
   localparam logic [PRIO_W-1:0] PRIO_BOOST = 3'h4;
   // ------------------------------------------------------------
   // reset values and arbiter states
   // ------------------------------------------------------------
   localparam logic [MID_W-1:0] LAST_GRANT_RST = 2'h3;  // so master 0 is first
   localparam int               MAX_INFLIGHT   = 2;     // concurrent transfers
   typedef enum logic [0:0] {
      CSW_IDLE = 1'b0,                                   // slave free
      CSW_BUSY = 1'b1                                    // slave owned
   } csw_arb_e;
endpackage : csw_pkg

/* File: testbench/csw_master_model.sv */
// partner model: the four bus masters (fetch, load/store, dma, network)
// assumes: bench calls issue() just after a clock edge; one clock, sync reset
`timescale 1ns/10ps
module csw_master_model
   import csw_pkg::*;
(
   input  wire logic                       clk,      // system clock
   input  wire logic                       rst,      // sync reset, active high
   input  wire logic [NUM_MASTERS-1:0]     m_ready,  // transfer done per master
   output logic      [NUM_MASTERS-1:0]     m_req,    // request per master
   output logic      [NUM_MASTERS*SID_W-1:0] m_sel,  // target slave per master
   output logic      [NUM_MASTERS*ADDR_W-1:0] m_addr, // address per master
   output logic      [NUM_MASTERS-1:0]     m_write,  // write flag per master
   output logic      [NUM_MASTERS*DATA_W-1:0] m_wdata // write data per master
);
   // ------------------------------------------------------------
   // request launch and release
   // ------------------------------------------------------------
   initial begin
      m_req   = '0;
      m_sel   = '0;
      m_addr  = '0;
      m_write = '0;
      m_wdata = '0;
   end

   // raise a request; payload then stands until m_ready
   task automatic issue(input int m, input logic [SID_W-1:0] sel,
                        input logic [ADDR_W-1:0] a, input logic wr,
                        input logic [DATA_W-1:0] d);
      m_req[m]                    = 1'b1;
      m_sel[m*SID_W +: SID_W]     = sel;
      m_addr[m*ADDR_W +: ADDR_W]  = a;
      m_write[m]                  = wr;
      m_wdata[m*DATA_W +: DATA_W] = d;
   endtask : issue

   // drop at the accepting edge; target, address and write data are inverted so stale values never pass
   always @(posedge clk) begin
      for (int i = 0; i < NUM_MASTERS; i++) begin
         if (rst || (m_req[i] && m_ready[i])) begin
            m_req[i]                    <= 1'b0;
            m_sel[i*SID_W +: SID_W]     <= ~m_sel[i*SID_W +: SID_W];
            m_addr[i*ADDR_W +: ADDR_W]  <= ~m_addr[i*ADDR_W +: ADDR_W];
            m_wdata[i*DATA_W +: DATA_W] <= ~m_wdata[i*DATA_W +: DATA_W];
         end
      end
   end
endmodule : csw_master_model

/* File: testbench/tb_crossbar_switch_arbiter.sv */
// testbench: scenario tasks around the crossbar switch, slaves played inline
// assumes: masters come from csw_master_model; inputs change 1 ns after edges
`timescale 1ns/10ps
`define CHK(what, exp, got) \
   begin \
      tests_run++; \
      if ((exp) !== (got)) begin \
         fails++; \
         $display("unexpected %s: expected %0h seen %0h", what, exp, got); \
      end \
   end
module tb_crossbar_switch_arbiter;
   import csw_pkg::*;
   logic                       clk;      // 200 MHz clock
   logic                       rst;      // sync reset
   logic [NUM_MASTERS-1:0]     m_req;    // from master model
   logic [NUM_MASTERS*SID_W-1:0] m_sel;  // target slaves
   logic [NUM_MASTERS*ADDR_W-1:0] m_addr; // addresses
   logic [NUM_MASTERS-1:0]     m_write;  // write flags
   logic [NUM_MASTERS*DATA_W-1:0] m_wdata; // write data
   logic [NUM_MASTERS-1:0]     m_elev;   // elevation, driven here
   logic [NUM_MASTERS-1:0]     m_ready;  // per-master completion
   logic [NUM_MASTERS*DATA_W-1:0] m_rdata; // read data back
   logic [NUM_SLAVES-1:0]      s_valid;  // slave strobes
   logic [NUM_SLAVES*ADDR_W-1:0] s_addr; // slave addresses
   logic [NUM_SLAVES-1:0]      s_write;  // slave write flags
   logic [NUM_SLAVES*DATA_W-1:0] s_wdata; // slave write data
   logic [NUM_SLAVES*MID_W-1:0] s_master; // owner per slave
   logic [NUM_SLAVES-1:0]      s_ready;  // slave completion
   logic [NUM_SLAVES*DATA_W-1:0] s_rdata; // slave read data
   int                         fails;    // mismatches
   int                         tests_run; // comparisons

   csw_master_model i_mst (.clk(clk), .rst(rst), .m_ready(m_ready), .m_req(m_req),
      .m_sel(m_sel), .m_addr(m_addr), .m_write(m_write), .m_wdata(m_wdata));
   csw_crossbar_switch i_dut (.clk(clk), .rst(rst), .m_req(m_req), .m_sel(m_sel),
      .m_addr(m_addr), .m_write(m_write), .m_wdata(m_wdata), .m_elev(m_elev),
      .m_ready(m_ready), .m_rdata(m_rdata), .s_valid(s_valid), .s_addr(s_addr),
      .s_write(s_write), .s_wdata(s_wdata), .s_master(s_master), .s_ready(s_ready),
      .s_rdata(s_rdata));

   always #2.5 clk = ~clk;  // half period of 2.5 ns

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic step;
      @(posedge clk);
      #1;
   endtask : step
   function automatic logic [31:0] addr_of(input int m);
      return 32'hA000_0000 | (m * 32'h0000_0010);  // distinct per master
   endfunction : addr_of
   function automatic logic [31:0] data_of(input int m);
      return 32'h5A00_0000 | m;
   endfunction : data_of
   function automatic logic [MID_W-1:0] own(input int s);
      return s_master[s*MID_W +: MID_W];
   endfunction : own
   task automatic req(input int m, input logic [SID_W-1:0] sel);
      i_mst.issue(m, sel, addr_of(m), m[0], data_of(m));
   endtask : req

   // slave s checks owner m's payload, completes it one cycle after the call, then checks the read path
   task automatic serve(input int s, input int m, input logic [31:0] d);
      `CHK("slave addr", addr_of(m), s_addr[s*ADDR_W +: ADDR_W])
      `CHK("slave wdata", data_of(m), s_wdata[s*DATA_W +: DATA_W])
      `CHK("slave write", m[0], s_write[s])
      step;
      s_ready[s] = 1'b1;
      s_rdata[s*DATA_W +: DATA_W] = d;
      #1;
      `CHK("master ready", 4'(1 << m), m_ready)
      step;
      s_ready[s] = 1'b0;
      s_rdata[s*DATA_W +: DATA_W] = ~d;  // released data never looks valid
      `CHK("read data", d, m_rdata[m*DATA_W +: DATA_W])
   endtask : serve

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_lone;  // single master, idle slave
      req(1, S_SRAM);
      #1;
      `CHK("lone grant", 3'b010, s_valid)
      `CHK("lone owner", M_DATA, own(1))
      serve(1, 1, 32'hC0DE_0001);
   endtask : t_lone
   task automatic t_prio;  // load/store beats dma, dma waits its turn
      req(1, S_SRAM);
      req(2, S_SRAM);
      #1;
      `CHK("prio owner", M_DATA, own(1))
      serve(1, 1, 32'h1111_2222);
      `CHK("stalled next", M_DMA, own(1))
      serve(1, 2, 32'h3333_4444);
   endtask : t_prio
   task automatic t_rr;  // equal priority rotates after the last winner
      req(2, S_PBRG);
      req(3, S_PBRG);
      #1;
      `CHK("rr first", M_DMA, own(2))
      serve(2, 2, 32'h0BAD_F00D);
      req(2, S_PBRG);  // loser and fresh winner collide again
      #1;
      `CHK("rr second", M_NET, own(2))
      serve(2, 3, 32'hFACE_0003);
      `CHK("rr third", M_DMA, own(2))
      serve(2, 2, 32'hFACE_0002);
   endtask : t_rr
   task automatic t_elev;  // raised network master beats load/store
      m_elev[3] = 1'b1;
      req(1, S_SRAM);
      req(3, S_SRAM);
      #1;
      `CHK("elevated owner", M_NET, own(1))
      serve(1, 3, 32'hE1E7_0003);
      m_elev[3] = 1'b0;
      `CHK("after elevation", M_DATA, own(1))
      serve(1, 1, 32'hE1E7_0001);
   endtask : t_elev
   task automatic t_conc;  // fetch plus one more; a third is refused
      req(0, S_FLASH);
      req(1, S_SRAM);
      req(2, S_PBRG);
      #1;
      `CHK("two in flight", 3'b011, s_valid)
      `CHK("fetch on flash", M_INSTR, own(0))
      serve(0, 0, 32'hF00D_0000);
      `CHK("no fetch pair", 3'b010, s_valid)
      serve(1, 1, 32'hF00D_0001);
      `CHK("bridge last", 3'b100, s_valid)
      serve(2, 2, 32'hF00D_0002);
   endtask : t_conc

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize

   // watchdog: the whole sequence needs well under 200 cycles
   initial begin
      #5000;
      fails++;
      summarize();
   end

   // main sequence
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      m_elev = '0;
      s_ready = '0;
      s_rdata = '0;
      fails = 0;
      tests_run = 0;
      repeat (20) @(posedge clk);
      #1;
      rst = 1'b0;
      step;
      t_lone();
      t_prio();
      t_rr();
      t_elev();
      t_conc();
      summarize();
   end
endmodule : tb_crossbar_switch_arbiter
